// [bmc_bus_mode.sv]
// module: bus mode configuration register with strap capture and ahb slave
`timescale 1ns/10ps

// What this block does
// - strap level sets no register bit; it drives the processor-external output inverted, via the synchroniser
// - strap rising after release loads bus, emulation and rom bits
// - strap already high at reset release leaves every register bit zero
// - once locked strap is ignored; software writes reconfigure freely
// - rom-source zero, strap low: internal rom, external processor
// - rom-source zero with strap high: internal processor, internal rom
// - external-bus bit zero: ports are general i/o; one: external bus
// - rom-source bit maps top 8k region internal at zero, external at one
module bmc_bus_mode
    import bmc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        emulation_strap_input,
    output logic             ports_external_bus,
    output logic             tone_gen_zero_enable,
    output logic             tone_gen_one_enable,
    output logic             in_circuit_emulation,
    output logic             watchdog_enable,
    output logic             abort_on_port4_pin0,
    output logic             nmi_on_port4_pin0,
    output logic             top_rom_external,
    output logic             processor_external
);
    // =========================================================
    // strap synchroniser
    logic       strap_meta;
    logic       strap_sync;
    logic       strap_prev;
    logic       next_strap_meta;
    logic       next_strap_sync;
    logic       next_strap_prev;
    logic       strap_rise;

    always_comb begin
        next_strap_meta = emulation_strap_input;
        next_strap_sync = strap_meta;
        next_strap_prev = strap_sync;
    end

    // kept out of reset so the strap level is already known at release;
    // a reset value here would fake a rising edge for an early strap
    always_ff @(posedge hclk) begin
        strap_meta <= next_strap_meta;
        strap_sync <= next_strap_sync;
        strap_prev <= next_strap_prev;
    end

    assign strap_rise = strap_sync & ~strap_prev;

    // =========================================================
    // ahb-lite slave: address phase capture, zero-wait data phase
    logic        addr_ok;
    logic        wr_pend;
    logic        wr_mode;
    logic        next_wr_pend;
    logic        next_wr_mode;
    logic        wr_fire;

    assign addr_ok = hsel & hready & (htrans == BMC_HTRANS_NONSEQ);

    always_comb begin
        next_wr_pend = addr_ok & hwrite &
                       (haddr[15:0] == BMC_MODE_OFFSET);
        next_wr_mode = next_wr_pend;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_mode <= 1'b0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_mode <= next_wr_mode;
        end
    end

    assign wr_fire   = wr_pend & wr_mode;
    assign hreadyout = 1'b1;
    assign hresp     = BMC_HRESP_OKAY;

    // =========================================================
    // bus mode register and strap window
    logic [7:0]  mode;
    logic [7:0]  next_mode;
    bmc_strap_e  strap_st;
    bmc_strap_e  next_strap_st;

    always_comb begin
        next_mode     = mode;
        next_strap_st = strap_st;
        case (strap_st)
            // first edge after release: strap already high means all zero
            BMC_SAMPLE: begin
                if (strap_sync) begin
                    next_strap_st = BMC_LOCKED;
                end else begin
                    next_strap_st = BMC_ARMED;
                end
            end
            BMC_ARMED: begin
                if (strap_rise && !wr_fire) begin
                    next_mode     = BMC_EMUL_PRESET;
                    next_strap_st = BMC_LOCKED;
                end
            end
            BMC_LOCKED: begin
                next_strap_st = BMC_LOCKED;
            end
            default: begin
                next_strap_st = BMC_LOCKED;
            end
        endcase
        // a software write closes the strap window for good
        if (wr_fire) begin
            next_mode     = hwdata[7:0];
            next_strap_st = BMC_LOCKED;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode     <= BMC_MODE_RESET;
            strap_st <= BMC_SAMPLE;
        end else begin
            mode     <= next_mode;
            strap_st <= next_strap_st;
        end
    end

    // =========================================================
    // read data: mode taken from next values so a write just before is seen, status from current values
    logic [31:0] next_hrdata;
    logic [7:0]  status;

    always_comb begin
        status                   = 8'h00;
        status[BMC_ST_ARMED_BIT] = (strap_st != BMC_LOCKED);
        status[BMC_ST_STRAP_BIT] = strap_sync;
        // flags the forbidden double routing on the shared pin
        status[BMC_ST_CLASH_BIT] = mode[BMC_ABORT_BIT] & mode[BMC_NMI_BIT];
        next_hrdata = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            if (haddr[15:0] == BMC_MODE_OFFSET) begin
                next_hrdata = {24'h00_0000, next_mode};
            end else if (haddr[15:0] == BMC_STATUS_OFFSET) begin
                next_hrdata = {24'h00_0000, status};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // =========================================================
    // configuration outputs from the register flops; processor_external from the strap
    assign ports_external_bus   = mode[BMC_EXT_BUS_BIT];
    assign tone_gen_zero_enable = mode[BMC_TONE0_BIT];
    assign tone_gen_one_enable  = mode[BMC_TONE1_BIT];
    assign in_circuit_emulation = mode[BMC_EMUL_BIT];
    assign watchdog_enable      = mode[BMC_WDOG_BIT];
    // both routings may be set; the pin logic must not see both, yet both bits reach it unmasked
    assign abort_on_port4_pin0  = mode[BMC_ABORT_BIT];
    assign nmi_on_port4_pin0    = mode[BMC_NMI_BIT];
    assign top_rom_external     = mode[BMC_ROM_SRC_BIT];
    // strap low keeps the core off the bus for an external master
    assign processor_external   = ~strap_sync;

    // =========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_strap_emul: assert property (
        strap_st == BMC_ARMED && strap_rise && !wr_fire
        |=> mode == BMC_EMUL_PRESET && strap_st == BMC_LOCKED)
        else $error("strap rise did not load emulation setup");
    chk_emul_bits: assert property (
        $past(strap_st) == BMC_ARMED && !$past(wr_fire) &&
        $rose(mode[BMC_EMUL_BIT]) |->
        mode[BMC_EXT_BUS_BIT] && mode[BMC_ROM_SRC_BIT])
        else $error("emulation bits not set together");
    chk_strap_clear: assert property (
        strap_st == BMC_SAMPLE && strap_sync
        |=> mode == 8'h00 && strap_st == BMC_LOCKED)
        else $error("early strap did not leave register zero");
    chk_strap_ignored: assert property (
        strap_st == BMC_LOCKED && !wr_fire |=> $stable(mode))
        else $error("register changed without a write");
    chk_sw_write: assert property (
        addr_ok && hwrite && haddr[15:0] == BMC_MODE_OFFSET
        ##1 1'b1 |=> mode == $past(hwdata[7:0]))
        else $error("software write not stored");
    chk_dma_mode: assert property (
        !mode[BMC_ROM_SRC_BIT] && !strap_sync
        |-> !top_rom_external && processor_external)
        else $error("dma test mode not decoded");
    chk_int_rom: assert property (
        strap_sync |-> !processor_external &&
        top_rom_external == mode[BMC_ROM_SRC_BIT])
        else $error("internal processor rom select wrong");
    chk_port_bus: assert property (
        ports_external_bus == mode[BMC_EXT_BUS_BIT])
        else $error("port mode does not follow bit");
    chk_enables_map: assert property (
        {nmi_on_port4_pin0, abort_on_port4_pin0, watchdog_enable,
         in_circuit_emulation, tone_gen_one_enable,
         tone_gen_zero_enable} == mode[6:1])
        else $error("enable outputs do not follow bits");

    cov_emul_load: cover property (strap_st == BMC_ARMED && strap_rise);
    cov_early_strap: cover property (strap_st == BMC_SAMPLE && strap_sync);
    cov_sw_write: cover property (wr_fire);
    cov_clash: cover property (status[BMC_ST_CLASH_BIT]);
endmodule // bmc_bus_mode

// [bmc_pkg.sv]
// package: register map, field layout and states of the bus mode register
package bmc_pkg;
    // =========================================================
    // register map
    localparam logic [15:0] BMC_MODE_OFFSET   = 16'hdf40;
    localparam logic [15:0] BMC_STATUS_OFFSET = 16'hdf44;
    localparam logic [7:0]  BMC_MODE_RESET    = 8'h00;
    // =========================================================
    // bus mode register field positions
    localparam int BMC_EXT_BUS_BIT  = 0;
    localparam int BMC_TONE0_BIT    = 1;
    localparam int BMC_TONE1_BIT    = 2;
    localparam int BMC_EMUL_BIT     = 3;
    localparam int BMC_WDOG_BIT     = 4;
    localparam int BMC_ABORT_BIT    = 5;
    localparam int BMC_NMI_BIT      = 6;
    localparam int BMC_ROM_SRC_BIT  = 7;
    // value loaded when the strap rises after reset release
    localparam logic [7:0]  BMC_EMUL_PRESET   = 8'h89;
    // =========================================================
    // status register field positions
    localparam int BMC_ST_ARMED_BIT = 0;
    localparam int BMC_ST_STRAP_BIT = 1;
    localparam int BMC_ST_CLASH_BIT = 2;
    // =========================================================
    // ahb encodings
    localparam logic [1:0]  BMC_HTRANS_NONSEQ = 2'h2;
    localparam logic        BMC_HRESP_OKAY    = 1'h0;
    // =========================================================
    // strap tracking after reset release
    typedef enum logic [1:0] {
        BMC_SAMPLE,
        BMC_ARMED,
        BMC_LOCKED
    } bmc_strap_e;
endpackage

// [bmc_strap_pod.sv]
// partner model: emulation pod that drives the strap pin
`timescale 1ns/10ps
module bmc_strap_pod (
    input  wire logic hclk,
    input  wire logic raise,
    output logic      strap
);
    // =========================================================
    // strap output
    // pod changes the pin only on its own clock edge, never mid-cycle
    initial strap = 1'b0;
    always @(posedge hclk) begin
        strap <= raise;
    end
endmodule // bmc_strap_pod

// [tb_bmc.sv]
// testbench: bus mode register over ahb with the strap pod
`timescale 1ns/10ps
module tb;
    import bmc_pkg::*;
    // =========================================================
    // signals
    typedef struct packed {
        logic [15:0] a;
        logic [7:0]  w;
        logic [7:0]  e;
    } bmc_row_s;
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic             hwrite;
    logic             raise;
    logic      [31:0] haddr;
    logic      [31:0] hwdata;
    logic      [31:0] rd;
    logic      [1:0]  htrans;
    logic      [2:0]  hsize;
    wire logic [31:0] hrdata;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic        strap;
    wire logic        proc_ext;
    wire logic [7:0]  outs;
    int               error_cnt = 0;
    int               num_checks = 0;
    // abort and nmi routing set together only in the write to the unmapped address
    bmc_row_s rows [11] = '{'{16'hdf40, 8'h01, 8'h01},
        '{16'hdf40, 8'h02, 8'h02}, '{16'hdf40, 8'h04, 8'h04},
        '{16'hdf40, 8'h08, 8'h08}, '{16'hdf40, 8'h10, 8'h10},
        '{16'hdf40, 8'h20, 8'h20}, '{16'hdf40, 8'h40, 8'h40},
        '{16'hdf40, 8'h80, 8'h80}, '{16'hdf40, 8'h9f, 8'h9f},
        '{16'hdf48, 8'hff, 8'h9f}, '{16'hdf40, 8'h00, 8'h00}};
    bmc_strap_pod u_pod (.hclk(hclk), .raise(raise), .strap(strap));
    bmc_bus_mode u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .emulation_strap_input(strap), .ports_external_bus(outs[0]),
        .tone_gen_zero_enable(outs[1]), .tone_gen_one_enable(outs[2]),
        .in_circuit_emulation(outs[3]), .watchdog_enable(outs[4]),
        .abort_on_port4_pin0(outs[5]), .nmi_on_port4_pin0(outs[6]),
        .top_rom_external(outs[7]), .processor_external(proc_ext));
    // =========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // read data is taken at the data-phase edge, before it falls back
    task automatic ahb(input logic wr, input logic [15:0] a,
                       input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= BMC_HTRANS_NONSEQ;
        haddr <= {16'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0, "resp");
    endtask
    task automatic rd_mode(input logic [7:0] e, input string m);
        ahb(1'b0, BMC_MODE_OFFSET, 8'h00);
        chk(rd, {24'h0, e}, m);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // =========================================================
    // clock, watchdog, sequence
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        raise = 1'b0;
        repeat (2) @(posedge hclk);
        chk({24'h0, outs}, 32'h0, "reset outs");
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        chk({31'h0, proc_ext}, 32'h1, "dma test");
        rd_mode(8'h00, "armed");
        ahb(1'b0, BMC_STATUS_OFFSET, 8'h00);
        chk(rd, 32'h1, "status armed");
        foreach (rows[i]) begin
            ahb(1'b1, rows[i].a, rows[i].w);
            rd_mode(rows[i].e, "row mode");
            chk({24'h0, outs}, {24'h0, rows[i].e}, "row outs");
        end
        ahb(1'b0, 16'hdf48, 8'h00);
        chk(rd, 32'h0, "unmapped");
        // strap low at release and raised later: emulation preset
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        raise <= 1'b1;
        repeat (8) @(posedge hclk);
        // ext bus, emulation and rom source bits
        rd_mode(8'h89, "emul preset");
        chk({24'h0, outs}, 32'h89, "emul outs");
        chk({31'h0, proc_ext}, 32'h0, "internal cpu");
        ahb(1'b0, BMC_STATUS_OFFSET, 8'h00);
        chk(rd, 32'h2, "status locked");
        raise <= 1'b0;
        repeat (8) @(posedge hclk);
        rd_mode(8'h89, "strap fall");
        // strap already high well before release
        hresetn <= 1'b0;
        raise <= 1'b1;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        rd_mode(8'h00, "strap early");
        chk({31'h0, proc_ext}, 32'h0, "internal cpu");
        raise <= 1'b0;
        repeat (4) @(posedge hclk);
        raise <= 1'b1;
        repeat (8) @(posedge hclk);
        rd_mode(8'h00, "locked");
        // a write before the strap rises closes the window
        hresetn <= 1'b0;
        raise <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b1, BMC_MODE_OFFSET, 8'h02);
        raise <= 1'b1;
        repeat (8) @(posedge hclk);
        rd_mode(8'h02, "write locks");
        report_and_stop();
    end
endmodule // tb
